// ### hot_plug_pkg.sv
`default_nettype none
package hot_plug_pkg;
  // Register byte offsets (AXI4-Lite, one aligned word each)
  localparam logic [11:0] SLOT_STATUS_CTRL_ADDR = 12'h080;
  localparam logic [11:0] HP_USER_CFG_ADDR = 12'hf70;
  localparam logic [11:0] SLOT_CTRL_EXT_ADDR = 12'hf74;
  localparam logic [11:0] SLOT_SENSE_ADDR = 12'hf78;
  // Slot status event field 80h[24:16]
  localparam int EVT_LSB = 16;
  localparam int EVT_W = 9;
  // Slot control fields in 80h
  localparam int ATTN_CTRL_LSB = 6;
  localparam int PWR_IND_LSB = 8;
  localparam int PWR_CTRL_BIT = 10;
  // User configuration bits in F70h
  localparam int SW_HP_EN_BIT = 12;
  localparam int SER_OVR_DIS_BIT = 19;
  localparam logic [31:0] HP_USER_CFG_MASK = 32'h0008_1000;
  // Own control register F74h
  localparam int SLOT_EN_BIT = 0;
  localparam int PRES_SRC_BIT = 1;
  localparam int IRQ_PIN_BIT = 2;
  localparam int D3HOT_BIT = 3;
  localparam int UPSTREAM_BIT = 4;
  localparam int PAR_CAP_BIT = 5;
  localparam int SER_CAP_BIT = 6;
  localparam logic [31:0] SLOT_CTRL_EXT_MASK = 32'h0000_007f;
  // Indicator encodings (2-bit control fields)
  localparam logic [1:0] IND_ON = 2'h1;
  localparam logic [1:0] IND_BLINK = 2'h2;
  localparam logic [1:0] IND_OFF = 2'h3;
  // Blink timing
  localparam int CLK_HZ = 125_000_000;
  localparam int ATTN_BLINK_HZ = 1;
  localparam int PWR_BLINK_HZ = 2;
  localparam int ATTN_HALF_CYCLES = CLK_HZ / (2 * ATTN_BLINK_HZ);
  localparam int PWR_HALF_CYCLES = CLK_HZ / (2 * PWR_BLINK_HZ);
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Lamp and slot pin bundle
  typedef struct packed {
    logic attention_lamp_n;
    logic power_lamp_n;
    logic slot_refclk_enable_n;
    logic slot_reset_n;
    logic slot_power_enable;
  } slot_pins_t;
  typedef enum logic [1:0] {
    AXI_IDLE = 2'b00,
    AXI_RESP = 2'b01
  } axi_state_t;
endpackage
`default_nettype wire

// ### hot_plug_slot_controller.sv
// Our own choices: the register offsets and the AXI4-Lite slave port.
`default_nettype none
// Summary of operation
// (R1) Attention lamp blinks at 1 Hz, equal on and off halves.
// (R2) Power lamp blinks at 2 Hz, equal on and off halves.
// (R3) Power lamp: off unpowered, on when locked, blink during power change.
// (R4) Attention lamp: off normally, on for problem, blink to identify slot.
// (R5) Latch sense low means latch closed, high means open.
// (R6) Disabled slot: refclk enable high, slot reset low.
// (R7) Disabled slot: power enable low, both lamp outputs high.
// (R8) Status events read-only; clear bits writable while software hot plug enable set.
// (R9) Software setting a clear status bit raises a hot plug interrupt.
// (R10) Writing one to a set status bit clears it.
// (R11) Injection also works on upstream ports.
// (R12) Expander alert prompts expander service over the I2C master port; code raises o_expander_request only in serial mode.
// (R13) Presence from receiver detect or from active-low presence input.
// (R14) Interrupts delivered in-band or on active-low pins.
// (R15) Hot plug event in D3hot issues power management event message.
// (R16) Same register set regardless of parallel or serial signalling.
// (R17) Parallel or serial signal set chosen per port.
// (R18) Serial port slot reset comes from general-purpose pin.
// (R19) Device-specific hot plug configuration held at F70h.
// (R20) Serial used when both capable unless override-disable bit set.
// (R21) Blink rates from free-running divider of core clock.
module hot_plug_slot_controller #(
  parameter int ATTN_HALF = hot_plug_pkg::ATTN_HALF_CYCLES,
  parameter int PWR_HALF = hot_plug_pkg::PWR_HALF_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // AXI4-Lite slave
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Slot sense inputs
  input wire logic i_latch_sense_n,
  input wire logic i_card_present_n,
  input wire logic i_rx_detect,
  input wire logic i_power_fault,
  input wire logic i_attention_button,
  input wire logic i_power_good,
  input wire logic i_gpio_reset_n,
  // Expander side
  input wire logic i_expander_alert_n,
  input wire logic i_expander_done,
  output logic o_expander_request,
  // Slot outputs
  output var hot_plug_pkg::slot_pins_t o_slot,
  output logic o_serial_mode,
  // Interrupt and power management
  output logic o_switch_irq_n,
  output logic o_partition_irq_n,
  output logic o_inband_irq,
  output logic o_pme_request
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0] user_cfg;
  logic [31:0] ctrl_ext;
  logic [1:0] attn_ctrl;
  logic [1:0] pwr_ind;
  logic pwr_ctrl;
  logic [hot_plug_pkg::EVT_W-1:0] evt;
  logic [31:0] sense_word;
  logic slot_en;
  logic card_present;
  logic latch_closed;
  logic present_q;
  logic latch_q;
  logic fault_q;
  logic button_q;
  logic pgood_q;
  logic alert_q;
  logic [hot_plug_pkg::EVT_W-1:0] hw_evt;
  logic [hot_plug_pkg::EVT_W-1:0] sw_set;
  logic [hot_plug_pkg::EVT_W-1:0] sw_clr;
  logic [hot_plug_pkg::EVT_W-1:0] next_evt;
  logic evt_rise;
  logic wr_fire;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_q;
  logic [31:0] w_q;
  // ------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------
  // Address and data may arrive in either order; latch each until both held
  assign wr_addr = aw_held ? aw_q : i_awaddr;
  assign wr_data = w_held ? w_q : i_wdata;
  assign wr_fire = !o_bvalid && (aw_held || i_awvalid) && (w_held || i_wvalid);
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 32'h0000_0000;
      o_bvalid <= 1'b0;
      o_bresp <= hot_plug_pkg::RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (wr_addr == hot_plug_pkg::SLOT_STATUS_CTRL_ADDR ||
                    wr_addr == hot_plug_pkg::HP_USER_CFG_ADDR ||
                    wr_addr == hot_plug_pkg::SLOT_CTRL_EXT_ADDR ||
                    wr_addr == hot_plug_pkg::SLOT_SENSE_ADDR) ?
                   hot_plug_pkg::RESP_OKAY : hot_plug_pkg::RESP_SLVERR;
      end
      else
      begin
        if (i_awvalid && o_awready)
        begin
          aw_held <= 1'b1;
          aw_q <= i_awaddr;
        end
        if (i_wvalid && o_wready)
        begin
          w_held <= 1'b1;
          w_q <= i_wdata;
        end
        if (o_bvalid && i_bready)
          o_bvalid <= 1'b0;
      end
    end
  end
  // Ready only while nothing is pending on that channel
  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready = !w_held && !o_bvalid;
  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // Byte lanes 0..2 honoured only at 80h; F70h and F74h ignore strobes, bits fixed by mask
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      user_cfg <= 32'h0000_0000;
      ctrl_ext <= 32'h0000_0060;
      attn_ctrl <= hot_plug_pkg::IND_OFF;
      pwr_ind <= hot_plug_pkg::IND_OFF;
      pwr_ctrl <= 1'b1;
    end
    else if (wr_fire)
    begin
      if (wr_addr == hot_plug_pkg::HP_USER_CFG_ADDR)
        user_cfg <= wr_data & hot_plug_pkg::HP_USER_CFG_MASK; // R19
      if (wr_addr == hot_plug_pkg::SLOT_CTRL_EXT_ADDR)
        ctrl_ext <= wr_data & hot_plug_pkg::SLOT_CTRL_EXT_MASK;
      if (wr_addr == hot_plug_pkg::SLOT_STATUS_CTRL_ADDR && i_wstrb[0])
        attn_ctrl <= wr_data[hot_plug_pkg::ATTN_CTRL_LSB +: 2];
      if (wr_addr == hot_plug_pkg::SLOT_STATUS_CTRL_ADDR && i_wstrb[1])
      begin
        pwr_ind <= wr_data[hot_plug_pkg::PWR_IND_LSB +: 2];
        pwr_ctrl <= wr_data[hot_plug_pkg::PWR_CTRL_BIT];
      end
    end
  end
  // ------------------------------------------------------------
  // Slot sensing
  // ------------------------------------------------------------
  // Inputs are synchronous; one register stage for edge detection
  assign latch_closed = !i_latch_sense_n; // R5
  assign card_present = ctrl_ext[hot_plug_pkg::PRES_SRC_BIT] ? i_rx_detect :
                        !i_card_present_n; // R13
  assign slot_en = ctrl_ext[hot_plug_pkg::SLOT_EN_BIT];
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      present_q <= 1'b0;
      latch_q <= 1'b0;
      fault_q <= 1'b0;
      button_q <= 1'b0;
      pgood_q <= 1'b0;
      alert_q <= 1'b0;
    end
    else
    begin
      present_q <= card_present;
      latch_q <= latch_closed;
      fault_q <= i_power_fault;
      button_q <= i_attention_button;
      pgood_q <= i_power_good;
      alert_q <= !i_expander_alert_n;
    end
  end
  // Slot status layout: 16 button, 17 fault, 18 latch, 19 presence, 20 power good
  always_comb
  begin
    hw_evt = '0;
    hw_evt[0] = i_attention_button && !button_q;
    hw_evt[1] = i_power_fault && !fault_q;
    hw_evt[2] = latch_closed != latch_q;
    hw_evt[3] = card_present != present_q;
    hw_evt[4] = i_power_good && !pgood_q;
  end
  // ------------------------------------------------------------
  // Slot status events
  // ------------------------------------------------------------
  // Injection works on any port, upstream included; set wins over clear
  always_comb
  begin
    sw_set = '0;
    sw_clr = '0;
    if (wr_fire && wr_addr == hot_plug_pkg::SLOT_STATUS_CTRL_ADDR && i_wstrb[2])
    begin
      sw_clr = wr_data[hot_plug_pkg::EVT_LSB +: hot_plug_pkg::EVT_W] & evt; // R10
      if (user_cfg[hot_plug_pkg::SW_HP_EN_BIT]) // R8 R11
        sw_set = wr_data[hot_plug_pkg::EVT_LSB +: hot_plug_pkg::EVT_W] & ~evt; // R9
    end
    next_evt = (evt & ~sw_clr) | sw_set | hw_evt;
  end
  assign evt_rise = |(next_evt & ~evt);
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      evt <= '0;
    else
      evt <= next_evt;
  end
  // ------------------------------------------------------------
  // Interrupt, PME and expander service
  // ------------------------------------------------------------
  // Level interrupt while any event stands; pin or in-band routing
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_switch_irq_n <= 1'b1;
      o_partition_irq_n <= 1'b1;
      o_inband_irq <= 1'b0;
      o_pme_request <= 1'b0;
      o_expander_request <= 1'b0;
    end
    else
    begin
      o_switch_irq_n <= !(|next_evt && ctrl_ext[hot_plug_pkg::IRQ_PIN_BIT]); // R14
      o_partition_irq_n <= !(|next_evt && ctrl_ext[hot_plug_pkg::IRQ_PIN_BIT]);
      o_inband_irq <= |next_evt && !ctrl_ext[hot_plug_pkg::IRQ_PIN_BIT];
      o_pme_request <= evt_rise && ctrl_ext[hot_plug_pkg::D3HOT_BIT]; // R15
      if (o_serial_mode && alert_q)
        o_expander_request <= 1'b1; // R12
      else if (i_expander_done)
        o_expander_request <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // Blink dividers
  // ------------------------------------------------------------
  // Free-running; lamps pick up phase mid-period, acceptable for indicators
  logic [31:0] attn_cnt;
  logic [31:0] pwr_cnt;
  logic attn_phase;
  logic pwr_phase;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      attn_cnt <= 32'h0000_0000;
      attn_phase <= 1'b0;
    end
    else if (attn_cnt == 32'(ATTN_HALF - 1))
    begin
      attn_cnt <= 32'h0000_0000;
      attn_phase <= !attn_phase; // R1 R21
    end
    else
      attn_cnt <= attn_cnt + 32'h0000_0001;
  end
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      pwr_cnt <= 32'h0000_0000;
      pwr_phase <= 1'b0;
    end
    else if (pwr_cnt == 32'(PWR_HALF - 1))
    begin
      pwr_cnt <= 32'h0000_0000;
      pwr_phase <= !pwr_phase; // R2 R21
    end
    else
      pwr_cnt <= pwr_cnt + 32'h0000_0001;
  end
  // ------------------------------------------------------------
  // Slot outputs
  // ------------------------------------------------------------
  // Serial selected when both capable unless override-disable is set
  logic next_serial;
  assign next_serial = ctrl_ext[hot_plug_pkg::SER_CAP_BIT] &&
    !(ctrl_ext[hot_plug_pkg::PAR_CAP_BIT] && user_cfg[hot_plug_pkg::SER_OVR_DIS_BIT]); // R17 R20
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_slot <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      o_serial_mode <= 1'b0;
    end
    else
    begin
      o_serial_mode <= next_serial;
      if (!slot_en)
      begin
        o_slot.attention_lamp_n <= 1'b1; // R7
        o_slot.power_lamp_n <= 1'b1; // R7
        o_slot.slot_power_enable <= 1'b0; // R7
        o_slot.slot_refclk_enable_n <= 1'b1; // R6
        o_slot.slot_reset_n <= 1'b0; // R6
      end
      else
      begin
        case (attn_ctrl) // R4
          hot_plug_pkg::IND_ON: o_slot.attention_lamp_n <= 1'b0;
          hot_plug_pkg::IND_BLINK: o_slot.attention_lamp_n <= attn_phase;
          default: o_slot.attention_lamp_n <= 1'b1;
        endcase
        case (pwr_ind) // R3
          hot_plug_pkg::IND_ON: o_slot.power_lamp_n <= 1'b0;
          hot_plug_pkg::IND_BLINK: o_slot.power_lamp_n <= pwr_phase;
          default: o_slot.power_lamp_n <= 1'b1;
        endcase
        o_slot.slot_power_enable <= !pwr_ctrl;
        o_slot.slot_refclk_enable_n <= !(!pwr_ctrl && pgood_q);
        // Expander reset too slow; serial ports use the GPIO reset
        o_slot.slot_reset_n <= next_serial ? i_gpio_reset_n : // R18
                               (!pwr_ctrl && pgood_q);
      end
    end
  end
  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Same map whatever the signalling mode
  assign sense_word = {26'h0, next_serial, card_present, latch_closed,
                       i_power_fault, i_power_good, alert_q};
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= hot_plug_pkg::RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      o_rvalid <= 1'b1;
      o_rresp <= hot_plug_pkg::RESP_OKAY;
      case (i_araddr) // R16
        hot_plug_pkg::SLOT_STATUS_CTRL_ADDR:
          o_rdata <= {7'h0, evt, 5'h0, pwr_ctrl, pwr_ind, attn_ctrl, 6'h0};
        hot_plug_pkg::HP_USER_CFG_ADDR: o_rdata <= user_cfg;
        hot_plug_pkg::SLOT_CTRL_EXT_ADDR: o_rdata <= ctrl_ext;
        hot_plug_pkg::SLOT_SENSE_ADDR: o_rdata <= sense_word;
        default:
        begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= hot_plug_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (o_rvalid && i_rready)
      o_rvalid <= 1'b0;
  end
  assign o_arready = !o_rvalid;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_disabled_outputs: assert property ( // R7
    !slot_en |=> (!o_slot.slot_power_enable && o_slot.power_lamp_n && o_slot.attention_lamp_n))
    else $error("disabled slot outputs wrong");
  a_disabled_clock: assert property ( // R6
    !slot_en |=> (o_slot.slot_refclk_enable_n && !o_slot.slot_reset_n))
    else $error("disabled slot clock or reset wrong");
  a_clear_on_one: assert property ( // R10
    (|sw_clr && hw_evt == '0 && sw_set == '0) |=> ((evt & $past(sw_clr)) == '0))
    else $error("status bit not cleared");
  a_ro_no_inject: assert property ( // R8
    (!user_cfg[hot_plug_pkg::SW_HP_EN_BIT] && hw_evt == '0) |=> ((evt & ~$past(evt)) == '0))
    else $error("status bit set without enable");
  a_inject_irq: assert property ( // R9
    (|sw_set && !ctrl_ext[hot_plug_pkg::IRQ_PIN_BIT]) |=> o_inband_irq)
    else $error("injected event raised no interrupt");
  a_pin_irq: assert property ( // R14
    (|next_evt && ctrl_ext[hot_plug_pkg::IRQ_PIN_BIT]) |=> !o_switch_irq_n)
    else $error("pin interrupt missing");
  a_pme_event: assert property ( // R15
    (evt_rise && ctrl_ext[hot_plug_pkg::D3HOT_BIT]) |=> o_pme_request)
    else $error("pme missing");
  a_serial_select: assert property ( // R20
    (ctrl_ext[hot_plug_pkg::SER_CAP_BIT] && !user_cfg[hot_plug_pkg::SER_OVR_DIS_BIT])
    |=> o_serial_mode)
    else $error("serial controller not selected");
  a_attn_steady: assert property ( // R1
    (attn_cnt != 32'(ATTN_HALF - 1)) |=> $stable(attn_phase))
    else $error("attention blink half period wrong");
  c_inject: cover property (|sw_set);
  c_blink: cover property (pwr_ind == hot_plug_pkg::IND_BLINK && slot_en);
  c_serial: cover property (o_expander_request);
endmodule
`default_nettype wire

// ### slot_partner.sv
`default_nettype none
module slot_partner (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Bench commands
  input wire logic i_latch_open,
  input wire logic i_card_in,
  input wire logic i_rx_seen,
  input wire logic i_alert,
  // Design outputs seen by the slot
  input wire hot_plug_pkg::slot_pins_t i_slot,
  input wire logic i_expander_request,
  // Slot and expander lines back to the design
  output logic o_latch_sense_n,
  output logic o_card_present_n,
  output logic o_rx_detect,
  output logic o_power_good,
  output logic o_gpio_reset_n,
  output var logic o_expander_alert_n,
  output var logic o_expander_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ramp;
  logic [1:0] busy;
  // ----------------------------------------
  // Slot hardware
  // ----------------------------------------
  // Latch and presence are plain levels
  assign o_latch_sense_n = i_latch_open;
  assign o_card_present_n = !i_card_in;
  assign o_rx_detect = i_card_in && i_rx_seen;
  // Supply good 7 cycles after enable; drops at once
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n || !i_slot.slot_power_enable)
      ramp <= 3'h0;
    else if (ramp != 3'h7)
      ramp <= ramp + 3'h1;
  end
  assign o_power_good = (ramp == 3'h7);
  // Reset from a general-purpose pin, held until power is good
  assign o_gpio_reset_n = o_power_good;
  // Expander keeps its alert low until serviced, then answers late
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      busy <= 2'h0;
      o_expander_done <= 1'b0;
      o_expander_alert_n <= 1'b1;
    end
    else
    begin
      o_expander_done <= 1'b0;
      if (i_alert)
        o_expander_alert_n <= 1'b0;
      if (i_expander_request && !o_expander_done)
        busy <= busy + 2'h1;
      if (busy == 2'h3)
      begin
        busy <= 2'h0;
        o_expander_done <= 1'b1;
        o_expander_alert_n <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### hot_plug_slot_controller_bench.sv
`default_nettype none
module hot_plug_slot_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ATTN_H = 8;
  localparam int PWR_H = 4;
  localparam int LIMIT = 20000;
  localparam logic [11:0] SCA = hot_plug_pkg::SLOT_STATUS_CTRL_ADDR;
  localparam logic [11:0] EXT = hot_plug_pkg::SLOT_CTRL_EXT_ADDR;
  localparam logic [11:0] CFG = hot_plug_pkg::HP_USER_CFG_ADDR;
  localparam logic [11:0] SNS = hot_plug_pkg::SLOT_SENSE_ADDR;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic latch_open = 1'b0, card_in = 1'b1, rx_seen = 1'b0, alert = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, latch_sense_n, card_present_n, rx_detect;
  logic power_good, gpio_reset_n, alert_n, exp_done, exp_req, serial_mode;
  logic switch_irq_n, partition_irq_n, inband_irq, pme;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd, mode;
  hot_plug_pkg::slot_pins_t slot;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int pme_count = 0;
  int h1, h2, p0;
  logic [4:0][7:0] modes = 40'h69_75_79_65_61;
  // Clock, timeout and pulse counting
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (pme === 1'b1)
      pme_count <= pme_count + 1;
    if (cycles == LIMIT)
    begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end
  hot_plug_slot_controller #(.ATTN_HALF(ATTN_H), .PWR_HALF(PWR_H)) dut (
    .i_core_clk(core_clk), .i_reset_n(reset_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_latch_sense_n(latch_sense_n),
    .i_card_present_n(card_present_n), .i_rx_detect(rx_detect), .i_power_fault(1'b0),
    .i_attention_button(1'b0), .i_power_good(power_good), .i_gpio_reset_n(gpio_reset_n),
    .i_expander_alert_n(alert_n), .i_expander_done(exp_done), .o_expander_request(exp_req),
    .o_slot(slot), .o_serial_mode(serial_mode), .o_switch_irq_n(switch_irq_n),
    .o_partition_irq_n(partition_irq_n), .o_inband_irq(inband_irq), .o_pme_request(pme));
  slot_partner far_side (
    .i_core_clk(core_clk), .i_reset_n(reset_n), .i_latch_open(latch_open),
    .i_card_in(card_in), .i_rx_seen(rx_seen), .i_alert(alert), .i_slot(slot),
    .i_expander_request(exp_req), .o_latch_sense_n(latch_sense_n),
    .o_card_present_n(card_present_n), .o_rx_detect(rx_detect), .o_power_good(power_good),
    .o_gpio_reset_n(gpio_reset_n), .o_expander_alert_n(alert_n), .o_expander_done(exp_done));
  // ----------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string w);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string w);
    check_word({31'h0, got}, {31'h0, exp}, w);
  endtask
  // Ready sampled mid-cycle; signals move only at edges
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_t, w_t, b_t;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t)
    begin
      @(negedge core_clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = (bvalid === 1'b1);
      rsp = bresp;
      @(posedge core_clk);
      if (aw_t)
        awvalid <= 1'b0;
      if (w_t)
        wvalid <= 1'b0;
      if (b_t)
        bready <= 1'b0;
    end
  endtask
  task automatic axi_read(input logic [11:0] a);
    logic ar_t, r_t;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t)
    begin
      @(negedge core_clk);
      ar_t = arvalid && arready;
      r_t = (rvalid === 1'b1);
      rd = rdata;
      rsp = rresp;
      @(posedge core_clk);
      if (ar_t)
        arvalid <= 1'b0;
      if (r_t)
        rready <= 1'b0;
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_read(a);
    check_word(rd & m, e, "register read");
  endtask
  // Cycles until the lamp next changes, seen mid-cycle
  task automatic half_period(input int lamp, output int n);
    logic last;
    @(negedge core_clk);
    last = slot[lamp];
    n = 1;
    while (slot[lamp] === last && n < 64)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    check_word(32'(slot), 32'h0000_001c, "disabled slot pins");
    rd_chk(EXT, 32'hffff_ffff, 32'h0000_0060);
    rd_chk(SCA, 32'h0000_0400, 32'h0000_0400);
    axi_read(12'h100);
    check_word(32'(rsp), 32'(hot_plug_pkg::RESP_SLVERR), "unmapped read");
    check_word(rd, 32'h0000_0000, "unmapped data");
    check_bit(serial_mode, 1'b1, "serial by default");
    $display("test reset done");
    axi_write(EXT, 32'h0000_0061, 4'hf);
    axi_write(SCA, 32'h0000_0000, 4'h2);
    repeat (12) @(negedge core_clk);
    check_word(32'(slot), 32'h0000_001b, "powered serial slot");
    @(posedge core_clk);
    alert <= 1'b1;
    @(posedge core_clk);
    alert <= 1'b0;
    for (int k = 0; k < 20 && exp_req !== 1'b1; k++) @(negedge core_clk);
    check_bit(exp_req, 1'b1, "expander serviced");
    for (int k = 0; k < 20 && exp_req !== 1'b0; k++) @(negedge core_clk);
    check_bit(exp_req, 1'b0, "expander released");
    axi_write(CFG, 32'h0008_0000, 4'hf);
    rd_chk(CFG, 32'hffff_ffff, 32'h0008_0000);
    check_bit(serial_mode, 1'b0, "override disables serial");
    check_bit(slot.slot_reset_n, 1'b1, "parallel reset released");
    $display("test power done");
    @(posedge core_clk);
    latch_open <= 1'b1;
    rd_chk(SNS, 32'h0000_0008, 32'h0000_0000);
    rd_chk(SCA, 32'h0004_0000, 32'h0004_0000);
    @(posedge core_clk);
    latch_open <= 1'b0;
    rd_chk(SNS, 32'h0000_0008, 32'h0000_0008);
    rd_chk(SNS, 32'h0000_0010, 32'h0000_0010);
    axi_write(EXT, 32'h0000_0063, 4'hf);
    rd_chk(SNS, 32'h0000_0010, 32'h0000_0000);
    axi_write(EXT, 32'h0000_0061, 4'hf);
    axi_write(SCA, 32'h01ff_0000, 4'h4);
    rd_chk(SCA, 32'h01ff_0000, 32'h0000_0000);
    check_bit(inband_irq, 1'b0, "no event pending");
    $display("test sense done");
    for (int i = 0; i < 2; i++)
    begin
      mode = i[0] ? 32'(hot_plug_pkg::IND_OFF) : 32'(hot_plug_pkg::IND_ON);
      axi_write(SCA, mode << 6, 4'h1);
      axi_write(SCA, mode << 8, 4'h2);
      repeat (2) @(negedge core_clk);
      check_bit(slot.attention_lamp_n, i[0], "attention steady");
      check_bit(slot.power_lamp_n, i[0], "power steady");
    end
    mode = 32'(hot_plug_pkg::IND_BLINK);
    axi_write(SCA, mode << 6, 4'h1);
    axi_write(SCA, mode << 8, 4'h2);
    half_period(4, h1);
    half_period(4, h1);
    half_period(4, h2);
    check_word(32'(h1), 32'(ATTN_H), "attention half");
    check_word(32'(h2), 32'(ATTN_H), "attention other half");
    half_period(3, h1);
    half_period(3, h1);
    half_period(3, h2);
    check_word(32'(h1), 32'(PWR_H), "power half");
    check_word(32'(h2), 32'(PWR_H), "power other half");
    $display("test lamps done");
    for (int b = 16; b < 21; b++)
    begin
      axi_write(SCA, 32'h1 << b, 4'h4);
      rd_chk(SCA, 32'h1 << b, 32'h0000_0000);
    end
    axi_write(CFG, 32'hffff_ffff, 4'hf);
    rd_chk(CFG, 32'hffff_ffff, hot_plug_pkg::HP_USER_CFG_MASK);
    for (int b = 16; b < 21; b++)
    begin
      mode = 32'(modes[b - 16]);
      axi_write(EXT, mode, 4'hf);
      p0 = pme_count;
      axi_write(SCA, 32'h1 << b, 4'h4);
      rd_chk(SCA, 32'h1 << b, 32'h1 << b);
      check_bit(inband_irq, !mode[2], "in-band interrupt");
      check_bit(switch_irq_n, !mode[2], "pin interrupt");
      check_bit(partition_irq_n, !mode[2], "second pin interrupt");
      check_bit(pme_count != p0, mode[3], "power event message");
      axi_write(SCA, 32'h1 << b, 4'h4);
      rd_chk(SCA, 32'h1 << b, 32'h0000_0000);
      check_bit(inband_irq | !switch_irq_n, 1'b0, "interrupt withdrawn");
    end
    axi_write(SCA, 32'h0001_0000, 4'h4);
    axi_write(CFG, 32'h0000_0000, 4'hf);
    axi_write(SCA, 32'h0001_0000, 4'h4);
    rd_chk(SCA, 32'h0001_0000, 32'h0000_0000);
    $display("test injection done");
    print_verdict();
  end
endmodule
`default_nettype wire
